//--- mae_pkg.sv
// shared constants and types for the instruction execution block
package mae_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] REG_CMD      = 4'h0; // write: execute one instruction
  localparam logic [3:0] REG_WREG     = 4'h1; // working register
  localparam logic [3:0] REG_STATUS   = 4'h2; // flags and run state
  localparam logic [3:0] REG_PC       = 4'h3; // program counter, read only
  localparam logic [3:0] REG_MEM_ADDR = 4'h4; // data memory window address
  localparam logic [3:0] REG_MEM_DATA = 4'h5; // data memory window data
  localparam logic [3:0] REG_STACK    = 4'h6; // write pushes, read shows top
  localparam logic [3:0] REG_WDOG     = 4'h7; // watchdog count, read only

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int ST_C    = 0; // borrow-out / carry
  localparam int ST_AC   = 1; // half_borrow_nibble_flag
  localparam int ST_Z    = 2; // result-null
  localparam int ST_OV   = 3; // signed_wrap_flag
  localparam int ST_PDF  = 4; // sleep_entered_flag
  localparam int ST_TO   = 5; // watchdog_expired_flag
  localparam int ST_EMI  = 6; // global_irq_enable
  localparam int ST_HALT = 7; // powered down, read only

  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_OP_W     = 5;
  localparam int CMD_TO_ACC   = 5;  // 1: result to working register only
  localparam int CMD_OPND_LSB = 8;  // memory address or immediate byte
  localparam int CMD_JMP_LSB  = 16; // jump target

  // ----------------------------------------------------------------
  // arithmetic constants and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] BCD_MAX   = 4'h9;
  localparam logic [3:0] BCD_STEP  = 4'h6;
  localparam logic [7:0] ONE_BYTE  = 8'h01;
  localparam logic [7:0] WREG_RST  = 8'h00;
  localparam int         IRQ_VECTOR = 4;

  typedef enum logic [4:0] {
    OP_NOP, OP_INVERT, OP_DAA, OP_DEC, OP_INC, OP_MOV_MA, OP_MOV_IA,
    OP_MOV_AM, OP_OR_M, OP_OR_I, OP_HALT, OP_JUMP, OP_RET, OP_RET_I,
    OP_INTERRUPT_RETURN_OP, OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SBC
  } mae_op_t;

endpackage

//--- mae_alu_if.sv
// operands and results passed between the sequencer and the datapath
`timescale 1ns/1ns
`default_nettype none
interface mae_alu_if;
  mae_pkg::mae_op_t op;
  logic             to_acc;  // result variant selector
  logic [7:0]       acc;
  logic [7:0]       mem;
  logic [7:0]       imm;
  logic             c_in;
  logic             ac_in;
  logic [7:0]       result;
  logic             wr_acc;
  logic             wr_mem;
  logic             upd_z;
  logic             upd_c;
  logic             upd_acov; // half borrow and signed wrap
  logic             c_out;
  logic             ac_out;
  logic             ov_out;

  modport core (output op, to_acc, acc, mem, imm, c_in, ac_in,
                input result, wr_acc, wr_mem, upd_z, upd_c, upd_acov,
                c_out, ac_out, ov_out);
  modport alu  (input op, to_acc, acc, mem, imm, c_in, ac_in,
                output result, wr_acc, wr_mem, upd_z, upd_c, upd_acov,
                c_out, ac_out, ov_out);
endinterface
`default_nettype wire

//--- mae_alu.sv
// combinational datapath for the executed instruction
`timescale 1ns/1ns
`default_nettype none
module mae_alu (
  mae_alu_if.alu a  // operands in, result and flag updates out
);
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic       lo_adj;
  logic       hi_adj;
  logic [8:0] bcd;

  // subtract and decimal adjust helpers
  always_comb begin
    diff   = {1'b0, a.acc} - {1'b0, a.mem} - {8'h00, ~a.c_in};
    ndiff  = {1'b0, a.acc[3:0]} - {1'b0, a.mem[3:0]} - {4'h0, ~a.c_in};
    lo_adj = (a.acc[3:0] > mae_pkg::BCD_MAX) || a.ac_in;
    hi_adj = (a.acc[7:4] > mae_pkg::BCD_MAX) || a.c_in;
    bcd    = {1'b0, a.acc} + {1'b0, (hi_adj ? mae_pkg::BCD_STEP : 4'h0),
                                    (lo_adj ? mae_pkg::BCD_STEP : 4'h0)};
  end

  // per-opcode result, destination and flag selection
  always_comb begin
    a.result   = 8'h00;
    a.wr_acc   = 1'b0;
    a.wr_mem   = 1'b0;
    a.upd_z    = 1'b0;
    a.upd_c    = 1'b0;
    a.upd_acov = 1'b0;
    a.c_out    = a.c_in;
    a.ac_out   = a.ac_in;
    a.ov_out   = 1'b0;
    unique case (a.op)
      mae_pkg::OP_INVERT: begin
        a.result = ~a.mem;
        a.upd_z  = 1'b1;
      end
      mae_pkg::OP_DAA: begin
        a.result = bcd[7:0];
        a.upd_c  = 1'b1;
        a.c_out  = hi_adj | bcd[8];
      end
      mae_pkg::OP_DEC: begin
        a.result = a.mem - mae_pkg::ONE_BYTE;
        a.upd_z  = 1'b1;
      end
      mae_pkg::OP_INC: begin
        a.result = a.mem + mae_pkg::ONE_BYTE;
        a.upd_z  = 1'b1;
      end
      mae_pkg::OP_MOV_MA: a.result = a.mem;
      mae_pkg::OP_MOV_IA: a.result = a.imm;
      mae_pkg::OP_MOV_AM: a.result = a.acc;
      mae_pkg::OP_OR_M: begin
        a.result = a.acc | a.mem;
        a.upd_z  = 1'b1;
      end
      mae_pkg::OP_OR_I: begin
        a.result = a.acc | a.imm;
        a.upd_z  = 1'b1;
      end
      mae_pkg::OP_RET_I: a.result = a.imm;
      mae_pkg::OP_RL: a.result = {a.mem[6:0], a.mem[7]};
      mae_pkg::OP_RLC: begin
        a.result = {a.mem[6:0], a.c_in};
        a.upd_c  = 1'b1;
        a.c_out  = a.mem[7];
      end
      mae_pkg::OP_RR: a.result = {a.mem[0], a.mem[7:1]};
      mae_pkg::OP_RRC: begin
        a.result = {a.c_in, a.mem[7:1]};
        a.upd_c  = 1'b1;
        a.c_out  = a.mem[0];
      end
      mae_pkg::OP_SBC: begin
        a.result   = diff[7:0];
        a.upd_z    = 1'b1;
        a.upd_c    = 1'b1;
        a.upd_acov = 1'b1;
        a.c_out    = ~diff[8];
        a.ac_out   = ~ndiff[4];
        a.ov_out   = (a.acc[7] ^ a.mem[7]) & (a.acc[7] ^ diff[7]);
      end
      default: a.result = 8'h00; // nop, halt, jump, return, interrupt return: no data
    endcase
    // destination: fixed-target forms first, then the variant bit
    unique case (a.op)
      mae_pkg::OP_MOV_MA, mae_pkg::OP_MOV_IA, mae_pkg::OP_OR_I,
      mae_pkg::OP_RET_I: a.wr_acc = 1'b1;
      mae_pkg::OP_MOV_AM, mae_pkg::OP_DAA: a.wr_mem = 1'b1;
      mae_pkg::OP_INVERT, mae_pkg::OP_DEC, mae_pkg::OP_INC, mae_pkg::OP_OR_M,
      mae_pkg::OP_RL, mae_pkg::OP_RLC, mae_pkg::OP_RR, mae_pkg::OP_RRC,
      mae_pkg::OP_SBC: begin
        a.wr_acc = a.to_acc;
        a.wr_mem = ~a.to_acc;
      end
      default: a.wr_acc = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- mae_wdog.sv
// watchdog prescaler and counter with expiry pulse
`timescale 1ns/1ns
`default_nettype none
module mae_wdog #(
  parameter int PRE_W = 8, // prescaler width
  parameter int CNT_W = 8  // watchdog_counter width
) (
  input  wire logic             sys_clk, // system clock
  input  wire logic             rst,     // synchronous reset
  input  wire logic             run,     // counts only while running
  input  wire logic             clr,     // clears counter and prescaler
  output logic      [CNT_W-1:0] count,   // watchdog_counter value
  output logic                  expired  // one-cycle pulse on wrap
);
  logic [PRE_W-1:0] pre_q;

  if (PRE_W < 1 || CNT_W < 1) begin : g_chk
    $error("watchdog widths must be positive");
  end

  // prescaler advances the counter once per full prescaler wrap
  always_ff @(posedge sys_clk) begin
    if (rst || clr) begin
      pre_q   <= '0;
      count   <= '0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (run) begin
        pre_q <= pre_q + 1'b1;
        if (&pre_q) begin
          count   <= count + 1'b1;
          expired <= &count;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- mae_exec.sv
// instruction execution block: sequencer, flags, data memory and stack
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - invert writes ones complement of memory byte, or to working reg; Z only
// - decimal adjust adds 6 to low nibble when above 9 or AC set
// - decimal adjust adds 6 to high nibble when above 9 or C set
// - decimal adjust result goes to memory; only C may change
// - decrement memory byte by one into memory or working reg; Z only
// - increment memory byte by one into memory or working reg; Z only
// - power-down stops execution and clock; all contents kept
// - power-down clears watchdog and prescaler, sets SLEEP_ENTERED_FLAG, clears TO
// - jump loads program counter, two cycles with dummy, no flags
// - moves copy memory, immediate or working reg, no flags
// - no-operation changes nothing but the program counter
// - OR working reg with memory or immediate; Z only
// - return pops program counter, flags unchanged
// - return-with-immediate pops counter and loads immediate to working reg
// - interrupt return pops counter and sets global interrupt enable
// - pending interrupt at interrupt return is serviced first
// - rotate left, bit 7 into bit 0, no flags
// - rotate left through carry, old C into bit 0, bit 7 into C
// - rotate right, bit 0 into bit 7, no flags
// - rotate right through carry, old C into bit 7, bit 0 into C
// - subtract with borrow: acc minus mem minus not C; OV Z AC C
// - after subtract with borrow, C is 0 if negative, else 1
module mae_exec #(
  parameter int MEM_DEPTH   = 64, // data memory bytes
  parameter int STACK_DEPTH = 4,  // call stack levels
  parameter int PC_W        = 11, // program counter width
  parameter int WDOG_PRE_W  = 8,  // watchdog prescaler width
  parameter int WDOG_CNT_W  = 8   // watchdog counter width
) (
  input  wire logic                       sys_clk,     // system clock
  input  wire logic                       rst,         // synchronous reset
  input  wire logic [mae_pkg::ADDR_W-1:0] addr,        // register address
  input  wire logic [mae_pkg::DATA_W-1:0] wr_data,     // write data
  input  wire logic                       wr_en,       // write strobe
  input  wire logic                       rd_en,       // read strobe
  output logic      [mae_pkg::DATA_W-1:0] rd_data,     // read data, next cycle
  input  wire logic                       irq_pending, // pin: interrupt waiting
  input  wire logic                       wake,        // pin: leave power-down
  output logic                            clk_run,     // system clock gate
  output logic                            irq_take     // pulse: vector taken
);

  // ----------------------------------------------------------------
  // parameter checks and derived sizes
  // ----------------------------------------------------------------
  localparam int MEM_AW = $clog2(MEM_DEPTH);
  localparam int SP_W   = $clog2(STACK_DEPTH);

  if (MEM_DEPTH < 2 || MEM_DEPTH > 256 || (1 << MEM_AW) != MEM_DEPTH) begin : g_mem_chk
    $error("MEM_DEPTH must be a power of two from 2 to 256");
  end
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_stk_chk
    $error("STACK_DEPTH must be a power of two of at least 2");
  end
  if (PC_W < 4 || PC_W > 16) begin : g_pc_chk
    $error("PC_W must lie between 4 and 16");
  end

  typedef enum logic [1:0] {S_RUN, S_DUMMY, S_HALT} mae_state_t;

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  mae_state_t          state_q;
  logic [PC_W-1:0]     pc_q;
  logic [7:0]          wreg_q;          // working_reg
  logic                c_q;
  logic                ac_q;            // half_borrow_nibble_flag
  logic                z_q;
  logic                ov_q;            // signed_wrap_flag
  logic                pdf_q;           // sleep_entered_flag
  logic                to_q;            // watchdog_expired_flag
  logic                emi_q;           // global_irq_enable
  logic [MEM_AW-1:0]   win_addr_q;
  logic [7:0]          mem_q [MEM_DEPTH];
  logic [PC_W-1:0]     stack_q [STACK_DEPTH];
  logic [SP_W-1:0]     sp_q;
  logic [1:0]          irq_sync_q;
  logic [1:0]          wake_sync_q;
  logic                irq_s;
  logic                wake_s;
  logic                exec;
  mae_pkg::mae_op_t    op;
  logic [7:0]          opnd;
  logic [MEM_AW-1:0]   opnd_addr;
  logic [PC_W-1:0]     stack_top;
  logic                pop;
  logic                push_sw;
  logic                divert;
  logic [WDOG_CNT_W-1:0] wdog_count;
  logic                wdog_expired;
  logic                wdog_clr;
  logic [7:0]          status_byte;

  mae_alu_if alu_bus ();

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pins come from outside the clock domain; only stage two is read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_sync_q  <= 2'b00;
      wake_sync_q <= 2'b00;
    end else begin
      irq_sync_q  <= {irq_sync_q[0], irq_pending};
      wake_sync_q <= {wake_sync_q[0], wake};
    end
  end
  assign irq_s  = irq_sync_q[1];
  assign wake_s = wake_sync_q[1];

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // a command is taken only in the run state; during the dummy cycle
  // or power-down it is dropped without any sign on the bus
  assign exec      = wr_en && (addr == mae_pkg::REG_CMD) && (state_q == S_RUN);
  assign op        = mae_pkg::mae_op_t'(wr_data[mae_pkg::CMD_OP_LSB +: mae_pkg::CMD_OP_W]);
  assign opnd      = wr_data[mae_pkg::CMD_OPND_LSB +: 8];
  assign opnd_addr = opnd[MEM_AW-1:0];
  assign stack_top = stack_q[sp_q - 1'b1];
  assign push_sw   = wr_en && (addr == mae_pkg::REG_STACK);
  // a pending request at interrupt return keeps the popped address on
  // the stack and heads straight for the vector
  assign divert    = exec && (op == mae_pkg::OP_INTERRUPT_RETURN_OP) && irq_s;
  assign pop       = exec && !divert && (op == mae_pkg::OP_RET ||
                     op == mae_pkg::OP_RET_I || op == mae_pkg::OP_INTERRUPT_RETURN_OP);
  assign wdog_clr  = exec && (op == mae_pkg::OP_HALT);

  // datapath operands
  assign alu_bus.op     = op;
  assign alu_bus.to_acc = wr_data[mae_pkg::CMD_TO_ACC];
  assign alu_bus.acc    = wreg_q;
  assign alu_bus.mem    = mem_q[opnd_addr];
  assign alu_bus.imm    = opnd;
  assign alu_bus.c_in   = c_q;
  assign alu_bus.ac_in  = ac_q;

  mae_alu u_alu (
    .a (alu_bus.alu)
  );

  mae_wdog #(
    .PRE_W (WDOG_PRE_W),
    .CNT_W (WDOG_CNT_W)
  ) u_wdog (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (state_q != S_HALT),
    .clr     (wdog_clr),
    .count   (wdog_count),
    .expired (wdog_expired)
  );

  // ----------------------------------------------------------------
  // sequencer and program counter
  // ----------------------------------------------------------------
  // jumps and returns spend one extra dummy cycle while the new
  // address loads; power-down holds until the wake pin rises
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= S_RUN;
      pc_q    <= '0;
    end else begin
      unique case (state_q)
        S_RUN: begin
          if (exec) begin
            pc_q <= pc_q + 1'b1;
            unique case (op)
              mae_pkg::OP_JUMP: begin
                pc_q    <= wr_data[mae_pkg::CMD_JMP_LSB +: PC_W];
                state_q <= S_DUMMY;
              end
              mae_pkg::OP_RET, mae_pkg::OP_RET_I: begin
                pc_q    <= stack_top;
                state_q <= S_DUMMY;
              end
              mae_pkg::OP_INTERRUPT_RETURN_OP: begin
                pc_q    <= divert ? PC_W'(mae_pkg::IRQ_VECTOR) : stack_top;
                state_q <= S_DUMMY;
              end
              mae_pkg::OP_HALT: state_q <= S_HALT;
              default: state_q <= S_RUN;
            endcase
          end
        end
        S_DUMMY: state_q <= S_RUN;
        S_HALT: begin
          if (wake_s) begin
            state_q <= S_RUN;
          end
        end
        default: state_q <= S_RUN;
      endcase
    end
  end

  // clock gate and interrupt hand-off, both straight from flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_run  <= 1'b1;
      irq_take <= 1'b0;
    end else begin
      irq_take <= divert;
      if (wdog_clr) begin
        clk_run <= 1'b0;
      end else if (state_q == S_HALT && wake_s) begin
        clk_run <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // call stack
  // ----------------------------------------------------------------
  // circular: overflow overwrites the oldest entry, underflow wraps
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sp_q <= '0;
    end else if (pop) begin
      sp_q <= sp_q - 1'b1;
    end else if (push_sw) begin
      stack_q[sp_q] <= wr_data[PC_W-1:0];
      sp_q          <= sp_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // working register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wreg_q <= mae_pkg::WREG_RST;
    end else if (wr_en && addr == mae_pkg::REG_WREG) begin
      wreg_q <= wr_data[7:0];
    end else if (exec && alu_bus.wr_acc) begin
      wreg_q <= alu_bus.result;
    end
  end

  // ----------------------------------------------------------------
  // data memory and its software window
  // ----------------------------------------------------------------
  // contents have no reset: power-down and reset both leave them alone
  always_ff @(posedge sys_clk) begin
    if (wr_en && addr == mae_pkg::REG_MEM_DATA) begin
      mem_q[win_addr_q] <= wr_data[7:0];
    end else if (exec && alu_bus.wr_mem) begin
      mem_q[opnd_addr] <= alu_bus.result;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      win_addr_q <= '0;
    end else if (wr_en && addr == mae_pkg::REG_MEM_ADDR) begin
      win_addr_q <= wr_data[MEM_AW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // software may write C, AC, Z, OV and the enable; the sleep and
  // expiry flags only move under hardware control
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      c_q   <= 1'b0;
      ac_q  <= 1'b0;
      z_q   <= 1'b0;
      ov_q  <= 1'b0;
      emi_q <= 1'b0;
    end else if (wr_en && addr == mae_pkg::REG_STATUS) begin
      c_q   <= wr_data[mae_pkg::ST_C];
      ac_q  <= wr_data[mae_pkg::ST_AC];
      z_q   <= wr_data[mae_pkg::ST_Z];
      ov_q  <= wr_data[mae_pkg::ST_OV];
      emi_q <= wr_data[mae_pkg::ST_EMI];
    end else if (exec) begin
      if (alu_bus.upd_z) begin
        z_q <= (alu_bus.result == 8'h00);
      end
      if (alu_bus.upd_c) begin
        c_q <= alu_bus.c_out;
      end
      if (alu_bus.upd_acov) begin
        ac_q <= alu_bus.ac_out;
        ov_q <= alu_bus.ov_out;
      end
      if (op == mae_pkg::OP_INTERRUPT_RETURN_OP) begin
        // a diverted return enters the handler, which masks again
        emi_q <= !divert;
      end
    end
  end

  // sleep and expiry flags; entering power-down beats a same-cycle
  // expiry because the watchdog is cleared at that moment
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pdf_q <= 1'b0;
      to_q  <= 1'b0;
    end else if (wdog_clr) begin
      pdf_q <= 1'b1;
      to_q  <= 1'b0;
    end else if (wdog_expired) begin
      to_q <= 1'b1;
    end
  end

  assign status_byte = {state_q == S_HALT, emi_q, to_q, pdf_q, ov_q, z_q, ac_q, c_q};

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // data stands for exactly one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      unique case (addr)
        mae_pkg::REG_WREG:     rd_data <= {24'h000000, wreg_q};
        mae_pkg::REG_STATUS:   rd_data <= {24'h000000, status_byte};
        mae_pkg::REG_PC:       rd_data <= {{(32 - PC_W){1'b0}}, pc_q};
        mae_pkg::REG_MEM_ADDR: rd_data <= {{(32 - MEM_AW){1'b0}}, win_addr_q};
        mae_pkg::REG_MEM_DATA: rd_data <= {24'h000000, mem_q[win_addr_q]};
        mae_pkg::REG_STACK:    rd_data <= {{(32 - PC_W){1'b0}}, stack_top};
        mae_pkg::REG_WDOG:     rd_data <= {{(32 - WDOG_CNT_W){1'b0}}, wdog_count};
        default:               rd_data <= '0;
      endcase
    end else begin
      rd_data <= '0;
    end
  end

endmodule
`default_nettype wire

//--- mae_chk.sv
// port-level assertions for the instruction execution block
`timescale 1ns/1ns
`default_nettype none
module mae_chk (
  input wire logic        sys_clk,     // clock
  input wire logic        rst,         // reset
  input wire logic [3:0]  addr,        // address
  input wire logic [31:0] wr_data,     // write data
  input wire logic        wr_en,       // write
  input wire logic        rd_en,       // read
  input wire logic [31:0] rd_data,     // read data
  input wire logic        irq_pending, // request pin
  input wire logic        wake,        // wake pin
  input wire logic        clk_run,     // clock gate
  input wire logic        irq_take     // vector taken
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // command decodes; a dropped command in a dummy cycle is not modelled
  wire halt = wr_en && addr == 4'h0 && wr_data[4:0] == 5'd10;
  wire interrupt_return_op = wr_en && addr == 4'h0 && wr_data[4:0] == 5'd14;
  a_rd_idle: assert property (!$past(rd_en) |-> rd_data == 32'h0) else $error("stale data");
  a_halt_stops: assert property (halt && clk_run |-> ##[1:2] !clk_run)
    else $error("gate still on");
  a_stop_cause: assert property ($fell(clk_run) |-> $past(halt) || $past(halt, 2))
    else $error("gate off unasked");
  a_stay_halted: assert property ((!wake) [*4] ##0 !clk_run |=> !clk_run)
    else $error("woke alone");
  a_wake_resume: assert property (wake && !clk_run |-> ##[1:6] clk_run)
    else $error("no wake");
  a_take_single: assert property (irq_take |=> !irq_take)
    else $error("long pulse");
  a_take_cause: assert property (irq_take |-> $past(interrupt_return_op) || $past(interrupt_return_op, 2))
    else $error("vector unasked");
  a_take_quiet: assert property ((!irq_pending) [*4] ##0 interrupt_return_op |=> !irq_take [*2])
    else $error("vector idle");
endmodule
bind mae_exec mae_chk mae_chk_inst (.sys_clk, .rst, .addr, .wr_data, .wr_en, .rd_en,
  .rd_data, .irq_pending, .wake, .clk_run, .irq_take);
`default_nettype wire

//--- mae_far.sv
// far-side pin source for interrupt request and wake
`timescale 1ns/1ns
`default_nettype none
module mae_far (
  input  wire logic want_irq,    // bench request
  input  wire logic want_wake,   // bench wake
  output wire logic irq_pending, // request pin
  output wire logic wake         // wake pin
);
  // pins move off the clock edge, as an unsynchronised source would
  assign #3 irq_pending = want_irq;
  assign #3 wake        = want_wake;
endmodule
`default_nettype wire

//--- test_mae_exec.sv
// self-checking bench for the instruction execution block
`timescale 1ns/1ns
`default_nettype none
`define CK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_mae_exec;
  logic            sys_clk, rst, wr_en, rd_en, want_irq, want_wake, ta;
  logic [3:0]      addr;
  logic [4:0]      op;
  logic [7:0]      a, m, x, s;
  logic [31:0]     wr_data, r2;
  logic [23:0]     e;
  wire logic [31:0] rd_data;
  wire logic       irq_pending, wake, clk_run, irq_take;
  int              miscompares = 0, num_checks = 0, seed = 46291;
  logic [4:0]      ops [15] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 15, 16, 17, 18, 19};
  logic [36:0]     cor [2] = '{37'h13_0001_0800, 37'h02_9900_0a03};
  mae_exec mae_exec_inst (.sys_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
                          .irq_pending, .wake, .clk_run, .irq_take);
  mae_far mae_far_inst (.want_irq, .want_wake, .irq_pending, .wake);
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // one-cycle write; the #1 keeps a following strobe out of this time step
  task automatic wr(logic [3:0] ad, logic [31:0] d);
    {wr_en, addr, wr_data} <= {1'b1, ad, d};
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  // read data are only valid in the cycle after the strobe
  task automatic rk(logic [3:0] ad, logic [31:0] ex);
    {rd_en, addr} <= {1'b1, ad};
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 `CK(rd_data, ex)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // expected {working reg, memory, status}; d picks the destination
  function automatic logic [23:0] model(logic [4:0] o, logic t, logic [7:0] a, m, x, s);
    logic [8:0] r;
    logic [4:0] l;
    logic [7:0] f;
    logic [1:0] d;
    f = s;
    d = t ? 2'd1 : 2'd2;
    r = {1'b0, m};
    l = a[3:0] - m[3:0] - !s[0];
    case (o)
      0: d = 0;
      1: r = ~m;
      2: begin
        d = 2;
        r = a + {1'b0, (a[7:4] > 9 || s[0]) ? 4'h6 : 4'h0, (a[3:0] > 9 || s[1]) ? 4'h6 : 4'h0};
        f[0] = r[8] || a[7:4] > 9 || s[0];
      end
      3: r = m - 1;
      4: r = m + 1;
      5: d = 1;
      6: {d, r} = {2'd1, 1'b0, x};
      7: {d, r} = {2'd2, 1'b0, a};
      8: r = a | m;
      9: {d, r} = {2'd1, 1'b0, a | x};
      15: r = {m[6:0], m[7]};
      16: {f[0], r[7:0]} = {m, s[0]};
      17: r = {m[0], m[7:1]};
      18: {r[7:0], f[0]} = {s[0], m};
      19: begin
        r = a - m - !s[0];
        f[3:0] = {(a[7] ^ m[7]) & (r[7] ^ a[7]), 1'b0, !l[4], !r[8]};
      end
      default: ;
    endcase
    if (o inside {1, 3, 4, 8, 9, 19}) f[2] = r[7:0] == 0;
    return {d == 1 ? r[7:0] : a, d == 2 ? r[7:0] : m, f};
  endfunction
  // hang guard, about three times the expected run
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {rst, wr_en, rd_en, want_irq, want_wake, addr, wr_data} = {5'h10, 36'h0};
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    // random operations, corners first
    for (int i = 0; i < 400; i++) begin
      r2 = $random(seed);
      {a, m, x, s} = $random(seed);
      op = ops[r2[3:0] % 4'd15];
      if (i < 2) {op, a, m, x, s} = cor[i];
      s[7:4] = 4'h0;
      ta = r2[8] && op inside {1, 3, 4, 8, [15:19]};
      wr(4'h4, {26'h0, x[5:0]});
      wr(4'h5, {24'h0, m});
      wr(4'h1, {24'h0, a});
      wr(4'h2, {24'h0, s});
      wr(4'h0, {16'h0, x, 2'b0, ta, op});
      e = model(op, ta, a, m, x, s);
      rk(4'h1, {24'h0, e[23:16]});
      rk(4'h5, {24'h0, e[15:8]});
      rk(4'h2, {24'h0, e[7:0]});
    end
    $display("random ops done");
    wr(4'h0, 32'h02c5_000b);
    rk(4'h3, 32'h2c5);
    rk(4'h2, {24'h0, e[7:0]});
    wr(4'h6, 32'h155);
    wr(4'h0, 32'h0000_000c);
    rk(4'h3, 32'h155);
    wr(4'h6, 32'h2aa);
    wr(4'h0, 32'h0000_5c0d);
    rk(4'h1, 32'h5c);
    wr(4'h2, 32'h0);
    wr(4'h6, 32'h0aa);
    wr(4'h0, 32'h0000_000e);
    rk(4'h2, 32'h40);
    want_irq <= 1'b1;
    wr(4'h6, 32'h077);
    repeat (3) @(posedge sys_clk);
    wr(4'h0, 32'h0000_000e);
    `CK(irq_take, 1'b1)
    rk(4'h3, 32'h4);
    rk(4'h6, 32'h77);
    want_irq <= 1'b0;
    wr(4'h0, 32'h0000_000a);
    repeat (2) @(posedge sys_clk);
    #1 `CK(clk_run, 1'b0)
    rk(4'h2, 32'h90);
    rk(4'h7, 32'h0);
    wr(4'h0, 32'h0000_3306);
    rk(4'h1, 32'h5c);
    want_wake <= 1'b1;
    repeat (20) if (clk_run !== 1'b1) @(posedge sys_clk);
    #1 `CK(clk_run, 1'b1)
    want_wake <= 1'b0;
    $display("flow and power-down done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
